// ===== common/cmoc_pkg.sv
/*
  Constants for the channel mix and output configuration block: bus offsets,
  control word field positions, reset values and PWM rate codes.
  Assumes the upper half (bits 63 to 32) of the 64-bit control word is held
  in one 32-bit staging register whose bit 0 is control bit 32.
*/
// Contract
// - Mix selection from control bits 46-49.
// - Upper mix bits pick left source.
// - Lower mix bits pick right source.
// - Mix selection resets to 1001.
// - Bit 50 gates the bridge drive.
// - Bridge drive cleared after reset.
// - N compensation resets 00000, tune 00000-01000.
// - P compensation resets 10000, tune 01000-10000.
// - P bits 51-55, N bits 56-60.
// - Bit 61 auto low power, gates silence.
// - Bit 62 selects modulator speed.
// - Bit 63 selects PWM method.
// - Speed and method set the PWM rate.
package cmoc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STAGE  = 4'h0;  // Staging of control bits 63..32.
  localparam logic [3:0] ADDR_COMMIT = 4'h4;  // Any write applies the staged word.
  localparam logic [3:0] ADDR_ACTIVE = 4'h8;  // Active control bits 63..32.
  localparam logic [3:0] ADDR_STATUS = 4'hC;  // Rate code, silence, FIFO level.

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CW_BASE   = 32;  // Control bit held in staging bit 0.
  localparam int MIX_LSB   = 46;  // Mix selection, four bits.
  localparam int BRIDGE    = 50;  // Bridge drive enable.
  localparam int PCOMP_LSB = 51;  // P-channel compensation, five bits.
  localparam int NCOMP_LSB = 56;  // N-channel compensation, five bits.
  localparam int ALP_BIT   = 61;  // Auto low power enable.
  localparam int SPD_BIT   = 62;  // Modulator speed.
  localparam int PWM_BIT   = 63;  // PWM method.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MIX_RST   = 4'h9;   // Left from left, right from right.
  localparam logic [4:0] PCOMP_RST = 5'h10;  // P compensation default.
  localparam logic [4:0] NCOMP_RST = 5'h00;  // N compensation default.
  localparam logic [31:0] CW_RST =
    (32'(MIX_RST) << (MIX_LSB - CW_BASE)) |
    (32'(PCOMP_RST) << (PCOMP_LSB - CW_BASE)) |
    (32'(NCOMP_RST) << (NCOMP_LSB - CW_BASE));

  // ----------------------------------------------------------------
  // Source selection and PWM rate codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_MUTE  = 2'h0;  // Silence.
  localparam logic [1:0] SRC_RIGHT = 2'h1;  // Right input.
  localparam logic [1:0] SRC_LEFT  = 2'h2;  // Left input.
  localparam logic [1:0] SRC_AVG   = 2'h3;  // Halved sum of both inputs.
  localparam logic [1:0] RATE_500K = 2'h0;  // 500 kHz.
  localparam logic [1:0] RATE_1M   = 2'h1;  // 1 MHz.
  localparam logic [1:0] RATE_2M   = 2'h2;  // 2 MHz.

endpackage

// ===== rtl/cmoc_mix_top.sv
/*
  Channel mixer and output stage configuration with an Avalon-MM slave,
  plus the sample FIFO that follows the mixer.
  Assumes one clock, samples synchronous to mclk, and a bus master that
  holds each request until it sees waitrequest low.
*/
// The register addresses and register access over Avalon-MM were chosen for this implementation.

// ------------------------------------------------------------------
// Sample FIFO with a registered head word
// ------------------------------------------------------------------
module cmoc_fifo #(
  parameter int W = 48,  // Word width.
  parameter int D = 8    // Depth of the array.
) (
  input  wire logic         mclk,     // Clock.
  input  wire logic         rst_b,    // Asynchronous reset, active low.
  input  wire logic         s_valid,  // Word offered.
  output logic              s_ready,  // Room for a word.
  input  wire logic [W-1:0] s_data,   // Word in.
  output logic              m_valid,  // Head word valid.
  input  wire logic         m_ready,  // Head word taken.
  output logic [W-1:0]      m_data,   // Head word.
  output logic [7:0]        level     // Words held in the array.
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];              // Storage.
  logic [AW-1:0] wr_reg, wr_next;     // Write pointer.
  logic [AW-1:0] rd_reg, rd_next;     // Read pointer.
  logic [AW:0]   cnt_reg, cnt_next;   // Fill count.
  logic          rdy_reg, rdy_next;   // Room flag.
  logic          mv_reg, mv_next;     // Head valid.
  logic [W-1:0]  md_reg, md_next;     // Head data.
  logic          push;                // Word accepted.
  logic          pop;                 // Word moved to head.

  // Next pointers, count and head; ready falls as soon as the array fills.
  always_comb begin
    push     = s_valid & rdy_reg;
    pop      = (cnt_reg != '0) & (~mv_reg | m_ready);
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    rdy_next = (cnt_next != (AW + 1)'(D));
    mv_next  = pop ? 1'b1 : (m_ready ? 1'b0 : mv_reg);
    md_next  = pop ? mem[rd_reg] : md_reg;
  end

  // Registers the FIFO state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      mv_reg  <= 1'b0;
      md_reg  <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      mv_reg  <= mv_next;
      md_reg  <= md_next;
    end
  end

  // Array write; the array has no reset.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_reg] <= s_data;
    end
  end

  assign s_ready = rdy_reg;
  assign m_valid = mv_reg;
  assign m_data  = md_reg;
  assign level   = 8'(cnt_reg);
endmodule

// ------------------------------------------------------------------
// Top: register slave, configuration and mixer
// ------------------------------------------------------------------
module cmoc_mix_top import cmoc_pkg::*; #(
  parameter int SW = 24,  // Sample width.
  parameter int FD = 8    // FIFO depth.
) (
  input  wire logic          mclk,              // Clock, 100 MHz.
  input  wire logic          rst_b,             // Asynchronous reset, active low.
  input  wire logic [3:0]    avs_address,       // Byte address.
  input  wire logic          avs_read,          // Read request.
  input  wire logic          avs_write,         // Write request.
  input  wire logic [31:0]   avs_writedata,     // Write data.
  input  wire logic [3:0]    avs_byteenable,    // Byte lanes.
  output logic [31:0]        avs_readdata,      // Read data.
  output logic               avs_waitrequest,   // Stall.
  input  wire logic          in_valid,          // Sample pair offered.
  output logic               in_ready,          // Sample pair accepted.
  input  wire logic [SW-1:0] in_left,           // Left input, signed.
  input  wire logic [SW-1:0] in_right,          // Right input, signed.
  output logic               out_valid,         // Mixed pair valid.
  input  wire logic          out_ready,         // Mixed pair taken.
  output logic [SW-1:0]      out_left,          // Left output.
  output logic [SW-1:0]      out_right,         // Right output.
  input  wire logic          silence_req,       // Digital silence wanted.
  output logic               silence_active,    // Digital silence granted.
  output logic               bridge_en,         // H-bridge drive enable.
  output logic [4:0]         pcomp,             // P-channel compensation.
  output logic [4:0]         ncomp,             // N-channel compensation.
  output logic               auto_low_power_enable, // Auto low power.
  output logic               pwm_speed,         // 1 is high speed.
  output logic               pwm_method,        // 1 is second method.
  output logic [1:0]         pwm_rate           // Rate code.
);
  logic [31:0] stage_reg, stage_next;    // Staged upper control word.
  logic [31:0] act_reg, act_next;        // Active upper control word.
  logic [1:0]  rate_reg, rate_next;      // Active rate code.
  logic        wait_reg, wait_next;      // Waitrequest.
  logic [31:0] rdata_reg, rdata_next;    // Read data.
  logic        sil_reg, sil_next;        // Silence grant.
  logic        acc;                      // Request present.
  logic        take;                     // Request completes this edge.
  logic        commit;                   // Staged word applied this edge.
  logic [7:0]  level;                    // FIFO fill.
  logic [3:0]  mix_sel;                  // Active mix selection.
  logic [SW-1:0] avg;                    // Halved sum.
  logic [SW:0] sum;                      // Widened sum.
  logic [SW-1:0] mix_l, mix_r;           // Mixed samples.
  logic [1:0]  sel_l, sel_r;             // Source picks.

  // ----------------------------------------------------------------
  // Register slave and configuration
  // ----------------------------------------------------------------

  // Each request waits one cycle, then completes with waitrequest low.
  always_comb begin
    acc        = avs_read | avs_write;
    take       = acc & ~wait_reg;
    wait_next  = ~(acc & wait_reg);
    stage_next = stage_reg;
    act_next   = act_reg;
    rate_next  = rate_reg;
    rdata_next = rdata_reg;
    commit     = 1'b0;
    if (acc & wait_reg & avs_read) begin
      case (avs_address)
        ADDR_STAGE:  rdata_next = stage_reg;
        ADDR_ACTIVE: rdata_next = act_reg;
        ADDR_STATUS: rdata_next = {21'h000000, level, sil_reg, rate_reg};
        default:     rdata_next = 32'h00000000;  // Unmapped reads zero.
      endcase
    end
    if (take & avs_write) begin
      case (avs_address)
        ADDR_STAGE: begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
              stage_next[8*b +: 8] = avs_writedata[8*b +: 8];
            end
          end
        end
        ADDR_COMMIT: commit = 1'b1;
        default: commit = 1'b0;  // Unmapped writes are ignored.
      endcase
    end
    if (commit) begin
      act_next = stage_reg;
      case ({stage_reg[SPD_BIT - CW_BASE], stage_reg[PWM_BIT - CW_BASE]})
        2'b00:   rate_next = RATE_500K;
        2'b11:   rate_next = RATE_2M;
        default: rate_next = RATE_1M;
      endcase
    end
    sil_next = silence_req & act_reg[ALP_BIT - CW_BASE];
  end

  // Registers the slave and configuration state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= CW_RST;
      act_reg   <= CW_RST;
      rate_reg  <= RATE_500K;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
      sil_reg   <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      act_reg   <= act_next;
      rate_reg  <= rate_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      sil_reg   <= sil_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign silence_active  = sil_reg;
  assign bridge_en = act_reg[BRIDGE - CW_BASE];
  assign pcomp = act_reg[PCOMP_LSB - CW_BASE +: 5];
  assign ncomp = act_reg[NCOMP_LSB - CW_BASE +: 5];
  assign auto_low_power_enable = act_reg[ALP_BIT - CW_BASE];
  assign pwm_speed  = act_reg[SPD_BIT - CW_BASE];
  assign pwm_method = act_reg[PWM_BIT - CW_BASE];
  assign pwm_rate   = rate_reg;

  // ----------------------------------------------------------------
  // Mixer
  // ----------------------------------------------------------------

  // Picks each output source from the active selection per sample pair.
  always_comb begin
    mix_sel = act_reg[MIX_LSB - CW_BASE +: 4];
    sel_l   = mix_sel[3:2];
    sel_r   = mix_sel[1:0];
    sum = {in_left[SW-1], in_left} + {in_right[SW-1], in_right};
    avg = sum[SW:1];
    case (sel_l)
      SRC_RIGHT: mix_l = in_right;
      SRC_LEFT:  mix_l = in_left;
      SRC_AVG:   mix_l = avg;
      default:   mix_l = '0;
    endcase
    case (sel_r)
      SRC_RIGHT: mix_r = in_right;
      SRC_LEFT:  mix_r = in_left;
      SRC_AVG:   mix_r = avg;
      default:   mix_r = '0;
    endcase
  end

  // Holds mixed pairs; back-pressure reaches the source through in_ready.
  cmoc_fifo #(.W(2 * SW), .D(FD)) u_fifo (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .s_valid (in_valid),
    .s_ready (in_ready),
    .s_data  ({mix_l, mix_r}),
    .m_valid (out_valid),
    .m_ready (out_ready),
    .m_data  ({out_left, out_right}),
    .level   (level)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_commit_mix;
    @(posedge mclk) disable iff (!rst_b)
      commit |=> mix_sel == $past(stage_reg[MIX_LSB - CW_BASE +: 4]);
  endproperty
  a_commit_mix: assert property (p_commit_mix) else $error("mix not applied");

  property p_left_src;
    @(posedge mclk) disable iff (!rst_b)
      (sel_l == SRC_MUTE) |-> mix_l == '0;
  endproperty
  a_left_src: assert property (p_left_src) else $error("left not muted");

  property p_right_src;
    @(posedge mclk) disable iff (!rst_b)
      (sel_r == SRC_RIGHT) |-> mix_r == in_right;
  endproperty
  a_right_src: assert property (p_right_src) else $error("right source wrong");

  property p_avg;
    @(posedge mclk) disable iff (!rst_b)
      (sel_l == SRC_AVG) |-> int'($signed(mix_l)) == ((int'($signed(in_left)) + int'($signed(in_right))) >>> 1);
  endproperty
  a_avg: assert property (p_avg) else $error("average wrong");

  property p_bridge;
    @(posedge mclk) disable iff (!rst_b)
      commit |=> bridge_en == $past(stage_reg[BRIDGE - CW_BASE]);
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge not applied");

  property p_hold;
    @(posedge mclk) disable iff (!rst_b)
      !commit |=> $stable(act_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed early");

  property p_rate;
    @(posedge mclk) disable iff (!rst_b)
      commit |=> pwm_rate == ((pwm_speed & pwm_method) ? RATE_2M :
                              (pwm_speed | pwm_method) ? RATE_1M : RATE_500K);
  endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");

  property p_silence;
    @(posedge mclk) disable iff (!rst_b)
      silence_active |-> $past(auto_low_power_enable) && $past(silence_req);
  endproperty
  a_silence: assert property (p_silence) else $error("silence without low power");

  property p_method;
    @(posedge mclk) disable iff (!rst_b)
      commit ##1 !commit |-> pwm_method == $past(stage_reg[PWM_BIT - CW_BASE], 2);
  endproperty
  a_method: assert property (p_method) else $error("method wrong");
endmodule

// ===== sim/cmoc_sink.sv
/*
  Sink model for the mixed sample stream, standing where the output stage sits.
  Assumes one clock and a stall input from the bench; records every pair taken.
*/
module cmoc_sink #(
  parameter int SW = 24  // Sample width.
) (
  input  wire logic          mclk,       // Clock.
  input  wire logic          rst_b,      // Reset, active low.
  input  wire logic          out_valid,  // Pair offered.
  output logic               out_ready,  // Pair taken.
  input  wire logic [SW-1:0] out_left,   // Left sample.
  input  wire logic [SW-1:0] out_right,  // Right sample.
  input  wire logic          stall       // Refuse everything from the cycle after it goes high.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2*SW-1:0] got_q[$];  // Pairs received, left in the upper half.

  // Takes pairs at random moments so the stream sees back pressure.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid === 1'b1 && out_ready) begin
        got_q.push_back({out_left, out_right});
      end
      out_ready <= !stall && ($urandom_range(3) != 0);
    end
  end
endmodule

// ===== sim/channel_mix_output_config_tb.sv
/*
  Self-checking bench for the mixer and output configuration block.
  Assumes the package constants and a 100 MHz clock; the sink model takes the output.
*/
module channel_mix_output_config_tb import cmoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, in_valid, in_ready;
  logic out_valid, out_ready, silence_req, silence_active, bridge_en, auto_low_power_enable;
  logic pwm_speed, pwm_method, stall;
  logic [3:0]  avs_address, avs_byteenable;  // Bus address and lanes.
  logic [31:0] avs_writedata, avs_readdata, q, w, prev;  // Bus data and words.
  logic [23:0] in_left, in_right, out_left, out_right, l, r;  // Samples.
  logic [4:0]  pcomp, ncomp;  // Compensation outputs.
  logic [1:0]  pwm_rate;  // Rate code.
  logic [3:0]  act_mix;  // Mix selection the bench believes active.
  logic [47:0] exp_q[$];  // Pairs expected at the sink.
  int err_total, comparisons, i, n, acc;

  cmoc_mix_top #(.SW(24), .FD(8)) dut (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready), .in_left(in_left),
    .in_right(in_right), .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
    .out_right(out_right), .silence_req(silence_req), .silence_active(silence_active),
    .bridge_en(bridge_en), .pcomp(pcomp), .ncomp(ncomp), .auto_low_power_enable(auto_low_power_enable),
    .pwm_speed(pwm_speed), .pwm_method(pwm_method), .pwm_rate(pwm_rate));
  cmoc_sink #(.SW(24)) u_sink (.mclk(mclk), .rst_b(rst_b), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right), .stall(stall));

  // Free-running clock, 10 ns period.
  always #5 mclk = ~mclk;

  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    $display("FAIL %0t wait ran out", $time);
    complete_run();
  endtask

  // Expected source for one output: mute, right, left or floored half sum.
  function automatic logic [23:0] src(input logic [1:0] s, input logic [23:0] a, input logic [23:0] b);
    logic signed [24:0] sum;
    sum = $signed({a[23], a}) + $signed({b[23], b});
    case (s)
      2'h0: return 24'h000000;
      2'h1: return b;
      2'h2: return a;
      default: return sum[24:1];
    endcase
  endfunction

  // Expected rate code from speed and method.
  function automatic logic [1:0] rate(input logic s, input logic h);
    return (s & h) ? RATE_2M : ((s | h) ? RATE_1M : RATE_500K);
  endfunction

  // --------------------------------------------------------------
  // Bus and stream drivers
  // --------------------------------------------------------------
  // One Avalon cycle held until waitrequest is seen low, then a spare edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) timeout();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Offers one pair until taken; valid stays up unless it is the last.
  task automatic send(input logic [23:0] a, input logic [23:0] b, input logic last);
    int k;
    in_valid <= 1'b1;
    in_left <= a;
    in_right <= b;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (in_ready !== 1'b1 && k < 200);
    if (k >= 200) timeout();
    if (last) in_valid <= 1'b0;
    exp_q.push_back({src(act_mix[3:2], a, b), src(act_mix[1:0], a, b)});
  endtask

  // Waits for the sink to catch up and compares every pair in order.
  task automatic drain();
    int k;
    k = 0;
    while (u_sink.got_q.size() < exp_q.size() && k < 800) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 800) timeout();
    while (exp_q.size() > 0) check(u_sink.got_q.pop_front(), exp_q.pop_front());
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0; rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; in_valid = 1'b0; in_left = 24'h0;
    in_right = 24'h0; silence_req = 1'b0; stall = 1'b0; err_total = 0; comparisons = 0;
    void'($urandom(63745));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check({bridge_en, pcomp, ncomp, pwm_rate}, {1'b0, PCOMP_RST, NCOMP_RST, RATE_500K});
    @(posedge mclk);
    bus(1'b0, ADDR_ACTIVE, 32'h0, q);
    check(q, CW_RST);
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    act_mix = MIX_RST;
    for (i = 0; i < 4; i++) send(24'($urandom), 24'($urandom), i == 3);
    drain();
    $display("test reset values done");
    prev = CW_RST;
    // first setting picks the second method at 1 MHz.
    for (i = 0; i < 16; i++) begin
      // host keeps compensation within the tuning ranges.
      // Bridge stays off on the first setting.
      w = {~i[1], i[0], i[2], 5'($urandom_range(8)), 5'(8 + $urandom_range(8)),
           1'($urandom) & (i != 0), i[3:0], 14'($urandom)};
      silence_req <= 1'($urandom);
      bus(1'b1, ADDR_STAGE, w, q);
      bus(1'b0, ADDR_ACTIVE, 32'h0, q);
      check(q, prev);
      bus(1'b1, ADDR_COMMIT, 32'h0, q);
      @(negedge mclk);
      check({bridge_en, pcomp, ncomp, auto_low_power_enable}, {w[18], w[23:19], w[28:24], w[29]});
      check({pwm_speed, pwm_method, pwm_rate}, {w[30], w[31], rate(w[30], w[31])});
      check(silence_active, silence_req & w[29]);
      @(posedge mclk);
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      check(q[10:0], {8'h00, silence_req & w[29], rate(w[30], w[31])});
      bus(1'b0, ADDR_ACTIVE, 32'h0, q);
      check(q, w);
      prev = w;
      act_mix = w[17:14];
      send(24'h7FFFFF, 24'h7FFFFF, 1'b0);
      send(24'h800000, 24'h800000, 1'b0);
      send(24'h7FFFFF, 24'h800001, 1'b0);
      send(24'($urandom), 24'($urandom), 1'b1);
      drain();
    end
    $display("test mix codes and fields done");
    stall <= 1'b1;
    repeat (3) @(posedge mclk);
    n = 0;
    acc = 0;
    l = 24'($urandom);
    r = 24'($urandom);
    in_valid <= 1'b1;
    in_left <= l;
    in_right <= r;
    while (n < 12 && acc < 40) begin
      @(posedge mclk);
      if (in_ready === 1'b1) begin
        exp_q.push_back({src(act_mix[3:2], l, r), src(act_mix[1:0], l, r)});
        acc++;
        n = 0;
        l = 24'($urandom);
        r = 24'($urandom);
        in_left <= l;
        in_right <= r;
      end else begin
        n++;
      end
    end
    in_valid <= 1'b0;
    check(acc, 9);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q[10:3], 8'h08);
    stall <= 1'b0;
    drain();
    $display("test buffer full and drain done");
    avs_byteenable <= 4'h2;
    bus(1'b1, ADDR_STAGE, 32'hFFFFFFFF, q);
    avs_byteenable <= 4'hF;
    bus(1'b0, ADDR_STAGE, 32'h0, q);
    check(q, {prev[31:16], 8'hFF, prev[7:0]});
    bus(1'b0, ADDR_ACTIVE, 32'h0, q);
    check(q, prev);
    $display("test byte lanes done");
    complete_run();
  end
endmodule
